/* File: src/usrx_top.v */
// serial receiver with address filter, sync master clocking, axi4-lite regs
// Notes on behaviour
// - nine-bit mode captures ninth bit into status
// - filter active when address enable and nine-bit
// - filtered: buffer only frames with bit 8 set
// - filtered data frame: no buffer, no interrupt
// - discarded byte lost when next frame shifts
// - address enable ignored in eight-bit mode
// - unfiltered nine-bit: every frame delivered
// - continuous-receive enable turns reception on
// - async needs sync clear and port enable
// - buffered frame sets flag, irq if enabled
// - clearing continuous enable clears overrun
// - pins as inputs: peripheral drives them
// - address setup: single or continuous starts
// - clocked-mode bit selects synchronous mode
// - port enable assigns clock and data pins
// - clock-source bit: device drives clock line
// - sync master half-duplex versus transmitter
// - third frame into full buffer: overrun
// - overrun blocks transfers into buffer
// - stop bit low sets framing error, buffered
// - flag read-only, clears when buffer empty
`timescale 1ns/100ps
`default_nettype none
`include "usrx_regs.vh"
module usrx_top (
	// clock and reset
	input wire clk,
	input wire rstn,
	// axi4-lite write address
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// axi4-lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// serial pins
	input wire shared_data_line_in,
	output reg shared_clock_line_out,
	output reg shared_clock_line_oe,
	// half-duplex handshake with the neighbouring transmitter
	input wire tx_active,
	output reg rx_active,
	// interrupt request
	output reg receive_irq
);
	localparam [5:0] S_IDLE = 6'b000001;
	localparam [5:0] S_START = 6'b000010;
	localparam [5:0] S_DATA = 6'b000100;
	localparam [5:0] S_STOP = 6'b001000;
	localparam [5:0] S_SCLK = 6'b010000;
	localparam [5:0] S_FIN = 6'b100000;

	// software registers
	reg [7:3] receive_status_control_q;
	reg [7:0] ien_q;
	reg [7:0] transmit_status_control_q;
	reg [7:0] baud_q;
	reg [7:0] dir_q;
	reg overrun_error_q;
	reg overrun_error_d;
	// bus slave state
	reg aw_got_q;
	reg w_got_q;
	reg [7:0] aw_idx_q;
	reg aw_hi_q;
	reg [7:0] w_byte_q;
	reg w_lane_q;
	reg [7:0] rd_byte_c;
	reg rd_ok_c;
	// receiver state
	reg [5:0] st_q;
	reg [3:0] cnt_q;
	reg [3:0] bitn_q;
	reg [8:0] rsr_q;
	reg fe_q;
	reg done_q;
	reg [8:0] done_word_q;
	reg done_fe_q;
	reg done_is_sync_q;

	wire serial_port_enable = receive_status_control_q[`USRX_RC_SERIAL_PORT_ENABLE];
	wire rx9 = receive_status_control_q[`USRX_RC_RX9];
	wire single_receive_enable = receive_status_control_q[`USRX_RC_SINGLE_RECEIVE_ENABLE];
	wire continuous_receive_enable = receive_status_control_q[`USRX_RC_CONTINUOUS_RECEIVE_ENABLE];
	wire address_filter_enable = receive_status_control_q[`USRX_RC_ADDRESS_FILTER_ENABLE];
	wire sync_mode = transmit_status_control_q[`USRX_TX_SYNC];
	wire clock_source_master = transmit_status_control_q[`USRX_TX_CLOCK_SOURCE_MASTER];
	wire high_speed_baud_select = transmit_status_control_q[`USRX_TX_HIGH_SPEED_BAUD_SELECT];
	wire rxd = shared_data_line_in;
	wire tick;
	wire fifo_full;
	wire fifo_empty;
	wire [9:0] fifo_head;
	wire fifo_push;
	wire fifo_pop;
	wire frame_ok;
	wire ovf;

	// peripheral owns the pins only once both are set as inputs
	wire pins_free = dir_q[`USRX_DIR_DATA] & dir_q[`USRX_DIR_CLK];
	// address filtering only counts in nine-bit mode
	wire filter = rx9 & address_filter_enable;
	// async: sync clear and port on; single enable only in address setup
	wire async_en = serial_port_enable & ~sync_mode & pins_free &
		(continuous_receive_enable | (single_receive_enable & filter));
	// sync master: device makes the clock, idles while transmitter busy
	wire master_pins = serial_port_enable & sync_mode & clock_source_master & pins_free;
	wire sync_en = master_pins & (continuous_receive_enable | single_receive_enable) & ~tx_active;
	wire [3:0] last_bit = rx9 ? `USRX_LAST_BIT9 : `USRX_LAST_BIT8;
	wire [8:0] rsr_in = {rxd, rsr_q[8:1]};
	wire [8:0] word_w = rx9 ? rsr_q : {1'b0, rsr_q[8:1]};
	wire wr_fire = aw_got_q & w_got_q & ~s_axi_bvalid;
	wire rd_take = s_axi_arvalid & s_axi_arready;
	wire sync_single_done = st_q[5] & done_is_sync_q & single_receive_enable & ~continuous_receive_enable;

	usrx_baud u_baud (
		.clk(clk),
		.rstn(rstn),
		.en(async_en | sync_en),
		.high_speed_baud_select(high_speed_baud_select),
		.divisor(baud_q),
		.tick(tick)
	);

	// unfiltered frames always pass; filtered ones need bit 8 set
	assign frame_ok = ~filter | done_word_q[8];
	// overrun blocks every transfer until cleared
	assign fifo_push = done_q & ~overrun_error_q & frame_ok & ~fifo_full;
	assign ovf = done_q & ~overrun_error_q & frame_ok & fifo_full;
	assign fifo_pop = rd_take & rd_ok_c &
		(s_axi_araddr[9:2] == `USRX_IDX_RCBUF);

	usrx_rxfifo #(
		.W(10)
	) u_fifo (
		.clk(clk),
		.rstn(rstn),
		.push(fifo_push),
		.din({done_fe_q, done_word_q}),
		.pop(fifo_pop),
		.dout(fifo_head),
		.full(fifo_full),
		.empty(fifo_empty)
	);

	// overrun set wins over the clear made by dropping continuous enable
	always @* begin
		overrun_error_d = ovf | (overrun_error_q & continuous_receive_enable);
	end

	// receive state machine
	always @(posedge clk) begin
		if (!rstn) begin
			st_q <= S_IDLE;
			cnt_q <= 4'h0;
			bitn_q <= 4'h0;
			rsr_q <= 9'h000;
			fe_q <= 1'b0;
			done_q <= 1'b0;
			done_word_q <= 9'h000;
			done_fe_q <= 1'b0;
			done_is_sync_q <= 1'b0;
			shared_clock_line_out <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (st_q)
			S_IDLE: begin
				cnt_q <= 4'h0;
				bitn_q <= 4'h0;
				shared_clock_line_out <= 1'b0;
				if (sync_en) begin
					st_q <= S_SCLK;
				end else if (async_en && !rxd) begin
					st_q <= S_START;
				end
			end
			S_START: begin
				if (!async_en) begin
					st_q <= S_IDLE;
				end else if (tick) begin
					cnt_q <= cnt_q + 4'h1;
					if (cnt_q == `USRX_OSR_MID) begin
						cnt_q <= 4'h0;
						// a glitch shorter than half a bit is not a start
						st_q <= rxd ? S_IDLE : S_DATA;
					end
				end
			end
			S_DATA: begin
				if (!async_en) begin
					st_q <= S_IDLE;
				end else if (tick) begin
					cnt_q <= cnt_q + 4'h1;
					if (cnt_q == `USRX_OSR_LAST) begin
						// new frame overwrites any discarded word
						rsr_q <= rsr_in;
						bitn_q <= bitn_q + 4'h1;
						if (bitn_q == last_bit) begin
							st_q <= S_STOP;
						end
					end
				end
			end
			S_STOP: begin
				if (!async_en) begin
					st_q <= S_IDLE;
				end else if (tick) begin
					cnt_q <= cnt_q + 4'h1;
					if (cnt_q == `USRX_OSR_LAST) begin
						fe_q <= ~rxd;
						done_is_sync_q <= 1'b0;
						st_q <= S_FIN;
					end
				end
			end
			S_SCLK: begin
				if (!sync_en) begin
					st_q <= S_IDLE;
				end else if (tick) begin
					shared_clock_line_out <= ~shared_clock_line_out;
					// data is sampled on the falling clock edge
					if (shared_clock_line_out) begin
						rsr_q <= rsr_in;
						bitn_q <= bitn_q + 4'h1;
						if (bitn_q == last_bit) begin
							fe_q <= 1'b0;
							done_is_sync_q <= 1'b1;
							st_q <= S_FIN;
						end
					end
				end
			end
			S_FIN: begin
				done_q <= 1'b1;
				done_word_q <= word_w;
				done_fe_q <= fe_q;
				st_q <= S_IDLE;
			end
			default: begin
				st_q <= S_IDLE;
			end
			endcase
		end
	end

	// register read mux; reserved bits read zero
	always @* begin
		rd_byte_c = 8'h00;
		rd_ok_c = (s_axi_araddr[11:10] == 2'h0);
		if (s_axi_araddr[9:2] == `USRX_IDX_FLAG) begin
			rd_byte_c[`USRX_FLAG_RECEIVE_READY_FLAG] = ~fifo_empty;
		end else if (s_axi_araddr[9:2] == `USRX_IDX_RECEIVE_STATUS_CONTROL) begin
			rd_byte_c[7:3] = receive_status_control_q;
			rd_byte_c[`USRX_RC_FRAMING_ERROR] = fifo_head[9];
			rd_byte_c[`USRX_RC_OVERRUN_ERROR] = overrun_error_q;
			rd_byte_c[`USRX_RC_RECEIVED_NINTH_BIT] = fifo_head[8];
		end else if (s_axi_araddr[9:2] == `USRX_IDX_RCBUF) begin
			rd_byte_c = fifo_head[7:0];
		end else if (s_axi_araddr[9:2] == `USRX_IDX_IEN) begin
			rd_byte_c = ien_q;
		end else if (s_axi_araddr[9:2] == `USRX_IDX_TRANSMIT_STATUS_CONTROL) begin
			rd_byte_c = transmit_status_control_q;
		end else if (s_axi_araddr[9:2] == `USRX_IDX_BAUD) begin
			rd_byte_c = baud_q;
		end else if (s_axi_araddr[9:2] == `USRX_IDX_DIR) begin
			rd_byte_c = dir_q;
		end else begin
			rd_ok_c = 1'b0;
		end
		if (!rd_ok_c) begin
			rd_byte_c = 8'h00;
		end
	end

	// bus slave and software registers
	always @(posedge clk) begin
		if (!rstn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `USRX_RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `USRX_RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			aw_idx_q <= 8'h00;
			aw_hi_q <= 1'b0;
			w_byte_q <= 8'h00;
			w_lane_q <= 1'b0;
			receive_status_control_q <= 5'h00;
			ien_q <= `USRX_RST_ZERO;
			transmit_status_control_q <= `USRX_RST_TRANSMIT_STATUS_CONTROL;
			baud_q <= `USRX_RST_ZERO;
			dir_q <= `USRX_RST_DIR;
			overrun_error_q <= 1'b0;
		end else begin
			overrun_error_q <= overrun_error_d;
			// a finished single word in sync mode drops the single enable
			if (sync_single_done) begin
				receive_status_control_q[`USRX_RC_SINGLE_RECEIVE_ENABLE] <= 1'b0;
			end
			if (s_axi_awvalid && s_axi_awready) begin
				aw_idx_q <= s_axi_awaddr[9:2];
				aw_hi_q <= |s_axi_awaddr[11:10];
				aw_got_q <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_byte_q <= s_axi_wdata[7:0];
				w_lane_q <= s_axi_wstrb[0];
				w_got_q <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `USRX_RESP_OKAY;
				if (aw_hi_q) begin
					s_axi_bresp <= `USRX_RESP_SLVERR;
				end else if (aw_idx_q == `USRX_IDX_RECEIVE_STATUS_CONTROL) begin
					if (w_lane_q) begin
						receive_status_control_q <= w_byte_q[7:3];
					end
				end else if (aw_idx_q == `USRX_IDX_IEN) begin
					if (w_lane_q) begin
						ien_q <= w_byte_q;
					end
				end else if (aw_idx_q == `USRX_IDX_TRANSMIT_STATUS_CONTROL) begin
					if (w_lane_q) begin
						transmit_status_control_q <= (w_byte_q & `USRX_TX_WMASK) |
							(`USRX_RST_TRANSMIT_STATUS_CONTROL & ~`USRX_TX_WMASK);
					end
				end else if (aw_idx_q == `USRX_IDX_BAUD) begin
					if (w_lane_q) begin
						baud_q <= w_byte_q;
					end
				end else if (aw_idx_q == `USRX_IDX_DIR) begin
					if (w_lane_q) begin
						dir_q <= w_byte_q;
					end
				end else if (aw_idx_q != `USRX_IDX_FLAG &&
					aw_idx_q != `USRX_IDX_RCBUF) begin
					// flag bank and buffer are read-only, writes dropped
					s_axi_bresp <= `USRX_RESP_SLVERR;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (rd_take) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h000000, rd_byte_c};
				s_axi_rresp <= rd_ok_c ? `USRX_RESP_OKAY :
					`USRX_RESP_SLVERR;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// pin drive, activity and interrupt flops
	always @(posedge clk) begin
		if (!rstn) begin
			shared_clock_line_oe <= 1'b0;
			rx_active <= 1'b0;
			receive_irq <= 1'b0;
		end else begin
			shared_clock_line_oe <= master_pins;
			// tells the transmitter to hold off while a word comes in
			rx_active <= ~st_q[0] & ~st_q[5] | (st_q[0] & sync_en);
			receive_irq <= ~fifo_empty & ien_q[`USRX_IEN_RECEIVE_INTERRUPT_ENABLE];
		end
	end
endmodule // usrx_top
`default_nettype wire

/* File: src/usrx_regs.vh */
// register indices, field positions, reset values and counts of the receiver
`ifndef USRX_REGS_VH
`define USRX_REGS_VH
// register indices; byte address is four times the index
`define USRX_IDX_FLAG 8'h0c
`define USRX_IDX_RECEIVE_STATUS_CONTROL 8'h18
`define USRX_IDX_RCBUF 8'h1a
`define USRX_IDX_IEN 8'h8c
`define USRX_IDX_TRANSMIT_STATUS_CONTROL 8'h98
`define USRX_IDX_BAUD 8'h99
`define USRX_IDX_DIR 8'h40
// receive_status_control fields
`define USRX_RC_SERIAL_PORT_ENABLE 7
`define USRX_RC_RX9 6
`define USRX_RC_SINGLE_RECEIVE_ENABLE 5
`define USRX_RC_CONTINUOUS_RECEIVE_ENABLE 4
`define USRX_RC_ADDRESS_FILTER_ENABLE 3
`define USRX_RC_FRAMING_ERROR 2
`define USRX_RC_OVERRUN_ERROR 1
`define USRX_RC_RECEIVED_NINTH_BIT 0
// flag and enable banks
`define USRX_FLAG_RECEIVE_READY_FLAG 5
`define USRX_IEN_RECEIVE_INTERRUPT_ENABLE 5
// transmit_status_control fields
`define USRX_TX_CLOCK_SOURCE_MASTER 7
`define USRX_TX_SYNC 4
`define USRX_TX_HIGH_SPEED_BAUD_SELECT 2
`define USRX_TX_WMASK 8'hf5
// port_direction_bits positions of the two serial pins
`define USRX_DIR_DATA 1
`define USRX_DIR_CLK 2
// reset values
`define USRX_RST_ZERO 8'h00
`define USRX_RST_TRANSMIT_STATUS_CONTROL 8'h02
`define USRX_RST_DIR 8'hff
// oversampling counts, prescale and buffer depth
`define USRX_OSR_MID 4'd7
`define USRX_OSR_LAST 4'd15
`define USRX_LAST_BIT9 4'd8
`define USRX_LAST_BIT8 4'd7
`define USRX_LOWSPD_PRE 2'd3
`define USRX_FIFO_DEPTH 2'd2
// bus responses
`define USRX_RESP_OKAY 2'b00
`define USRX_RESP_SLVERR 2'b10
`endif

/* File: src/usrx_baud.v */
// baud tick generator: one tick per oversample slot or sync half clock
`timescale 1ns/100ps
`default_nettype none
`include "usrx_regs.vh"
module usrx_baud (
	// clock and reset
	input wire clk,
	input wire rstn,
	// control
	input wire en,
	input wire high_speed_baud_select,
	input wire [7:0] divisor,
	// tick out
	output reg tick
);
	reg [1:0] pre_q;
	reg [7:0] cnt_q;
	wire step;

	// low speed divides by four more than high speed
	assign step = high_speed_baud_select | (pre_q == `USRX_LOWSPD_PRE);

	always @(posedge clk) begin
		if (!rstn || !en) begin
			pre_q <= 2'h0;
			cnt_q <= 8'h00;
			tick <= 1'b0;
		end else begin
			pre_q <= high_speed_baud_select ? 2'h0 : pre_q + 2'h1;
			tick <= 1'b0;
			if (step) begin
				if (cnt_q == divisor) begin
					cnt_q <= 8'h00;
					tick <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 8'h01;
				end
			end
		end
	end
endmodule // usrx_baud
`default_nettype wire

/* File: src/usrx_rxfifo.v */
// two-entry receive buffer holding data, ninth bit and framing error
`timescale 1ns/100ps
`default_nettype none
`include "usrx_regs.vh"
module usrx_rxfifo #(
	parameter W = 10
) (
	// clock and reset
	input wire clk,
	input wire rstn,
	// fill side
	input wire push,
	input wire [W-1:0] din,
	// drain side
	input wire pop,
	output wire [W-1:0] dout,
	// state
	output wire full,
	output wire empty
);
	reg [W-1:0] mem [0:1];
	reg wr_q;
	reg rd_q;
	reg [1:0] cnt_q;
	wire push_ok;
	wire pop_ok;

	assign full = (cnt_q == `USRX_FIFO_DEPTH);
	assign empty = (cnt_q == 2'h0);
	assign push_ok = push & ~full;
	assign pop_ok = pop & ~empty;
	// empty reads as zero so unwritten entries never leak out
	assign dout = empty ? {W{1'b0}} : mem[rd_q];

	always @(posedge clk) begin
		if (push_ok) begin
			mem[wr_q] <= din;
		end
	end

	always @(posedge clk) begin
		if (!rstn) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			if (push_ok) begin
				wr_q <= ~wr_q;
			end
			if (pop_ok) begin
				rd_q <= ~rd_q;
			end
			if (push_ok && !pop_ok) begin
				cnt_q <= cnt_q + 2'h1;
			end else if (pop_ok && !push_ok) begin
				cnt_q <= cnt_q - 2'h1;
			end
		end
	end
endmodule // usrx_rxfifo
`default_nettype wire

/* File: dv/usrx_monitor.sv */
// port assertions for the serial receiver top
`timescale 1ns/100ps
`default_nettype none
module usrx_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// pins and status
	input wire logic shared_clock_line_out,
	input wire logic shared_clock_line_oe,
	input wire logic tx_active,
	input wire logic rx_active,
	input wire logic receive_irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
	a_aw_refused: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("write address taken twice");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data above byte");
	a_clk_needs_oe: assert property ($rose(shared_clock_line_out) |-> shared_clock_line_oe)
		else $error("clock toggles undriven");
	a_half_duplex: assert property (shared_clock_line_oe && tx_active && !rx_active |=> !rx_active)
		else $error("receive starts while sending");
	cover property ($rose(receive_irq));
	cover property ($rose(shared_clock_line_oe));
	cover property ($rose(rx_active));
endmodule // usrx_monitor
`default_nettype wire

/* File: dv/usrx_remote_tx.sv */
// far-side serial transmitter sending asynchronous frames
`timescale 1ns/100ps
`default_nettype none
module usrx_remote_tx #(
	parameter BIT_CLKS = 16
) (
	// clock
	input wire logic clk,
	// serial line, idles high like a pulled-up wire
	output var logic line
);
	initial line = 1'b1;
	task automatic bit_out(input logic b);
		@(posedge clk);
		line <= b;
		repeat (BIT_CLKS - 1) @(posedge clk);
	endtask
	task automatic send(input logic [8:0] w, input logic nine, input logic stop);
		integer i;
		bit_out(1'b0);
		for (i = 0; i < (nine ? 9 : 8); i++) bit_out(w[i]);
		bit_out(stop);
		// one idle bit so a low stop never looks like a new start
		bit_out(1'b1);
	endtask
endmodule // usrx_remote_tx
`default_nettype wire

/* File: dv/testbench.sv */
// self-checking bench for the serial receiver with address filter
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic clk = 1'b0, rstn = 1'b0, tx_active = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire logic s_axi_rvalid, shared_clock_line_out, shared_clock_line_oe;
	wire logic rx_active, receive_irq, shared_data_line_in;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	integer err_count = 0, samples_checked = 0, i, j, n;
	logic [31:0] lfsr = 32'hc87171af, rd_d, r;
	logic [1:0] rd_r, wr_r;
	logic [9:0] q[$];
	logic [7:0] ctl = 8'h0;
	logic overrun_error = 1'b0, ien = 1'b0;
	logic [11:0] ra [7] = '{12'h260, 12'h060, 12'h230, 12'h264, 12'h030,
		12'h068, 12'h100};
	logic [7:0] rv [7] = '{8'h02, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'hff};
	logic [7:0] modes [4] = '{8'h90, 8'hd0, 8'hd8, 8'h98};
	always #4 clk = ~clk;
	usrx_top usrx_top_i (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .shared_data_line_in,
		.shared_clock_line_out, .shared_clock_line_oe, .tx_active,
		.rx_active, .receive_irq);
	usrx_remote_tx usrx_remote_tx_i (.clk, .line(shared_data_line_in));
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	task automatic chk(input string nm, input logic [31:0] s, e);
		samples_checked++;
		if (s !== e) begin
			err_count++;
			$display("FAIL %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic complete_run();
		if (err_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic timeout();
		err_count++;
		complete_run();
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		wr_r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n == 50) timeout();
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		rd_d = s_axi_rdata;
		rd_r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n == 50) timeout();
	endtask
	task automatic setc(input logic [7:0] c);
		ctl = c;
		if (!c[4]) overrun_error = 1'b0;
		wr(12'h060, c);
	endtask
	// model keeps {framing error, ninth bit, data} per buffered frame
	task automatic frame(input logic [8:0] w, input logic stop);
		logic en, drop;
		usrx_remote_tx_i.send(w, ctl[6], stop);
		en = ctl[7] && (ctl[4] || (ctl[5] && ctl[6] && ctl[3]));
		drop = ctl[6] && ctl[3] && !w[8];
		if (en && !drop && !overrun_error) begin
			if (q.size() == 2) overrun_error = 1'b1;
			else q.push_back({~stop, ctl[6] & w[8], w[7:0]});
		end
		chk("irq", receive_irq, q.size() != 0 && ien);
	endtask
	// status is read before data because the data read pops the entry
	task automatic pop_chk();
		logic [9:0] e;
		e = q.size() ? q[0] : 10'h0;
		rd(12'h030);
		chk("flag", rd_d, {26'h0, q.size() != 0, 5'h0});
		rd(12'h060);
		chk("status", rd_d, {24'h0, ctl[7:3], e[9], overrun_error, e[8]});
		rd(12'h068);
		chk("data", rd_d, {24'h0, e[7:0]});
		if (q.size()) void'(q.pop_front());
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		for (i = 0; i < 7; i++) begin
			rd(ra[i]);
			chk("reset value", rd_d, {24'h0, rv[i]});
		end
		rd(12'h3fc);
		chk("unmapped", rd_r, 2'b10);
		wr(12'h3fc, 8'h00);
		chk("unmapped write", wr_r, 2'b10);
		wr(12'h030, 8'hff);
		chk("flag write resp", wr_r, 2'b00);
		rd(12'h030);
		chk("flag read only", rd_d, 32'h0);
		wr(12'h264, 8'h00);
		wr(12'h260, 8'h04);
		wr(12'h230, 8'h20);
		ien = 1'b1;
		setc(8'h80);
		frame(9'h0a5, 1'b1);
		pop_chk();
		for (i = 0; i < 4; i++) begin
			setc(modes[i]);
			for (j = 0; j < 2; j++) begin
				r = rnd();
				frame({j[0], r[7:0]}, 1'b1);
				pop_chk();
			end
		end
		setc(8'he8);
		frame({1'b1, lfsr[15:8]}, 1'b1);
		pop_chk();
		// addressed slave drops the filter, data bytes now buffered
		setc(8'hd0);
		frame({1'b0, lfsr[23:16]}, 1'b1);
		pop_chk();
		setc(8'h90);
		for (i = 0; i < 3; i++) begin
			r = rnd();
			frame({1'b0, r[7:0]}, 1'b1);
		end
		pop_chk();
		pop_chk();
		frame(9'h03c, 1'b1);
		pop_chk();
		setc(8'h80);
		setc(8'h90);
		frame(9'h0c3, 1'b0);
		pop_chk();
		wr(12'h260, 8'h94);
		setc(8'h80);
		// pin enable is a flop behind the registers: look one edge later
		@(posedge clk);
		chk("clock oe", shared_clock_line_oe, 1'b1);
		wr(12'h100, 8'hf9);
		@(posedge clk);
		chk("clock oe dir", shared_clock_line_oe, 1'b0);
		wr(12'h100, 8'hff);
		tx_active <= 1'b1;
		setc(8'ha0);
		repeat (60) @(posedge clk);
		chk("busy irq", receive_irq, 1'b0);
		chk("busy rx idle", rx_active, 1'b0);
		chk("busy clock idle", shared_clock_line_out, 1'b0);
		tx_active <= 1'b0;
		for (n = 0; n < 300 && receive_irq !== 1'b1; n++) @(posedge clk);
		if (n == 300) timeout();
		// the idle-high data line shifts in as all ones
		q.push_back(10'h0ff);
		ctl = 8'h80;
		pop_chk();
		complete_run();
	end
endmodule // testbench
bind usrx_top usrx_monitor usrx_monitor_i (.clk, .rstn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .shared_clock_line_out,
	.shared_clock_line_oe, .tx_active, .rx_active, .receive_irq);
`default_nettype wire
